// File: rtl/gx_defs.svh
// Register indices, reset values and address constants of the expander.
// Behaviour
// - Alert is active while an unmasked input differs from its register.
// - Every interrupt mask bit is set after reset, so no alert appears.
// - Reset loads register defaults and idles the bus state machine.
// - After reset all sixteen pins are high-impedance inputs.
// - After reset pull resistors are enabled and select pull-up.
// - Low three target address bits come from the three strap pins.
// - Address byte last bit: 1 reads from the device, 0 writes to it.
// - Direction, input, output and polarity registers exist per 8-bit port.
// - A latched input keeps its changed value until its register is read.
// - A masked pin never raises the alert, even when its input changes.
// - Read-only status register per port shows which pins cause the alert.
// - Each 8-pin bank output stage is push-pull or open-drain as a whole.
// - Each pin has one of four programmable drive strengths.
// - Each pin may float or enable a resistor that pulls up or down.
// - The device is only a bus target and signals changes on the alert.
// - The byte after the address is stored as the register pointer.
// - Input registers show all pin levels; writes to them are ignored.
// - Direction bit 1 makes the pin an input, 0 makes it an output.
// - Drive field: 00b quarter, 01b half, 10b three quarters, 11b full.
`ifndef GX_DEFS_SVH
`define GX_DEFS_SVH

`define GX_REG_IN0 8'h00
`define GX_REG_IN1 8'h01
`define GX_REG_OUT0 8'h02
`define GX_REG_OUT1 8'h03
`define GX_REG_POL0 8'h04
`define GX_REG_POL1 8'h05
`define GX_REG_CFG0 8'h06
`define GX_REG_CFG1 8'h07
`define GX_REG_DRV0 8'h40
`define GX_REG_DRV1 8'h41
`define GX_REG_DRV2 8'h42
`define GX_REG_DRV3 8'h43
`define GX_REG_LAT0 8'h44
`define GX_REG_LAT1 8'h45
`define GX_REG_PEN0 8'h46
`define GX_REG_PEN1 8'h47
`define GX_REG_PSEL0 8'h48
`define GX_REG_PSEL1 8'h49
`define GX_REG_MASK0 8'h4A
`define GX_REG_MASK1 8'h4B
`define GX_REG_STAT0 8'h4C
`define GX_REG_STAT1 8'h4D
`define GX_REG_ODM 8'h4F

`define GX_OUT_RST 8'hFF
`define GX_POL_RST 8'h00
`define GX_CFG_RST 8'hFF
`define GX_DRV_RST 8'hFF
`define GX_LAT_RST 8'h00
`define GX_PEN_RST 8'hFF
`define GX_PSEL_RST 8'hFF
`define GX_MASK_RST 8'hFF
`define GX_ODM_RST 2'h0
`define GX_RD_UNMAPPED 8'h00

`define GX_ADDR_PREFIX 4'h2
`define GX_BYTE_BITS 4'h8

`endif

// File: rtl/gx_expander.sv
// Sixteen-pin port expander core with a two-wire serial target interface.
`include "gx_defs.svh"

module gx_expander (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    input wire logic [15:0] pin_in,
    output gx_pkg::gx_pin_ctl_type pin_ctl,
    output logic alert_n_out,
    output logic alert_n_oe
);

    gx_pkg::gx_core_state_type st;
    gx_pkg::gx_core_state_type next_st;
    gx_pkg::gx_pad_in_type pad_raw;
    gx_pkg::gx_pad_in_type pad;

    logic start_c;
    logic stop_c;
    logic rise_c;
    logic fall_c;
    logic [7:0] rd_data;
    logic [1:0] rd_in;
    logic [1:0][7:0] in_val;
    logic [1:0][7:0] shown;
    logic [1:0][7:0] status;
    logic [1:0][7:0] newly;

    assign pad_raw.scl = scl_in;
    assign pad_raw.sda = sda_in;
    assign pad_raw.strap = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
    assign pad_raw.pin = pin_in;

    gx_sync #(
        .W($bits(gx_pkg::gx_pad_in_type))
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .d(pad_raw),
        .q(pad)
    );

    // Bus conditions are judged on synchronised levels against last cycle.
    assign start_c = pad.scl & st.scl_d & st.sda_d & ~pad.sda;
    assign stop_c = pad.scl & st.scl_d & ~st.sda_d & pad.sda;
    assign rise_c = pad.scl & ~st.scl_d;
    assign fall_c = ~pad.scl & st.scl_d;

    // Input levels as software sees them, and the alert sources per port.
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            in_val[p] = pad.pin[p*8 +: 8] ^ st.pol[p];
            shown[p] = (st.lat[p] & st.flag[p] & st.lval[p]) |
                       (~(st.lat[p] & st.flag[p]) & in_val[p]);
            status[p] = ((in_val[p] ^ st.ref_val[p]) |
                         (st.lat[p] & st.flag[p])) & ~st.mask[p];
            newly[p] = st.lat[p] & ~st.flag[p] &
                       (in_val[p] ^ st.ref_val[p]);
        end
    end

    // Register read mux, addressed by the stored pointer.
    always_comb begin
        unique case (st.ptr)
            `GX_REG_IN0, `GX_REG_IN1: rd_data = shown[st.ptr[0]];
            `GX_REG_OUT0, `GX_REG_OUT1: rd_data = st.outp[st.ptr[0]];
            `GX_REG_POL0, `GX_REG_POL1: rd_data = st.pol[st.ptr[0]];
            `GX_REG_CFG0, `GX_REG_CFG1: rd_data = st.cfg[st.ptr[0]];
            `GX_REG_DRV0, `GX_REG_DRV1,
            `GX_REG_DRV2, `GX_REG_DRV3: rd_data = st.drv[st.ptr[1:0]];
            `GX_REG_LAT0, `GX_REG_LAT1: rd_data = st.lat[st.ptr[0]];
            `GX_REG_PEN0, `GX_REG_PEN1: rd_data = st.pen[st.ptr[0]];
            `GX_REG_PSEL0, `GX_REG_PSEL1: rd_data = st.psel[st.ptr[0]];
            `GX_REG_MASK0, `GX_REG_MASK1: rd_data = st.mask[st.ptr[0]];
            `GX_REG_STAT0, `GX_REG_STAT1: rd_data = status[st.ptr[0]];
            `GX_REG_ODM: rd_data = {6'h00, st.odm};
            default: rd_data = `GX_RD_UNMAPPED;
        endcase
    end

    always_comb begin
        next_st = st;
        rd_in = 2'h0;
        next_st.scl_d = pad.scl;
        next_st.sda_d = pad.sda;
        if (start_c) begin
            next_st.fsm = gx_pkg::ST_ADDR;
            next_st.bits = 4'h0;
            next_st.sda_oe = 1'b0;
        end else if (stop_c) begin
            next_st.fsm = gx_pkg::ST_IDLE;
            next_st.sda_oe = 1'b0;
        end else if (rise_c) begin
            unique case (st.fsm)
                gx_pkg::ST_ADDR, gx_pkg::ST_CMD, gx_pkg::ST_WR: begin
                    next_st.shift = {st.shift[6:0], pad.sda};
                    next_st.bits = st.bits + 4'h1;
                end
                gx_pkg::ST_RD: begin
                    next_st.bits = st.bits + 4'h1;
                end
                gx_pkg::ST_RACK: begin
                    // A not-acknowledge ends the read; wait for stop or start.
                    if (pad.sda) begin
                        next_st.fsm = gx_pkg::ST_IDLE;
                    end
                end
                gx_pkg::ST_IDLE, gx_pkg::ST_AACK, gx_pkg::ST_CACK,
                gx_pkg::ST_WACK: begin
                end
            endcase
        end else if (fall_c) begin
            unique case (st.fsm)
                gx_pkg::ST_ADDR: begin
                    if (st.bits == `GX_BYTE_BITS) begin
                        if (st.shift[7:1] == {`GX_ADDR_PREFIX,
                                              pad.strap}) begin
                            next_st.fsm = gx_pkg::ST_AACK;
                            next_st.rnw = st.shift[0];
                            next_st.sda_oe = 1'b1;
                        end else begin
                            next_st.fsm = gx_pkg::ST_IDLE;
                        end
                    end
                end
                gx_pkg::ST_AACK: begin
                    next_st.bits = 4'h0;
                    if (st.rnw) begin
                        next_st.fsm = gx_pkg::ST_RD;
                        next_st.shift = rd_data;
                        next_st.sda_oe = ~rd_data[7];
                        rd_in[st.ptr[0]] = (st.ptr[7:1] == 7'h00);
                    end else begin
                        next_st.fsm = gx_pkg::ST_CMD;
                        next_st.sda_oe = 1'b0;
                    end
                end
                gx_pkg::ST_CMD: begin
                    if (st.bits == `GX_BYTE_BITS) begin
                        next_st.fsm = gx_pkg::ST_CACK;
                        next_st.ptr = st.shift;
                        next_st.sda_oe = 1'b1;
                    end
                end
                gx_pkg::ST_CACK, gx_pkg::ST_WACK: begin
                    next_st.fsm = gx_pkg::ST_WR;
                    next_st.bits = 4'h0;
                    next_st.sda_oe = 1'b0;
                end
                gx_pkg::ST_WR: begin
                    if (st.bits == `GX_BYTE_BITS) begin
                        next_st.fsm = gx_pkg::ST_WACK;
                        next_st.sda_oe = 1'b1;
                        // Successive bytes alternate within a register pair.
                        next_st.ptr = {st.ptr[7:1], ~st.ptr[0]};
                        unique case (st.ptr)
                            `GX_REG_OUT0, `GX_REG_OUT1:
                                next_st.outp[st.ptr[0]] = st.shift;
                            `GX_REG_POL0, `GX_REG_POL1:
                                next_st.pol[st.ptr[0]] = st.shift;
                            `GX_REG_CFG0, `GX_REG_CFG1:
                                next_st.cfg[st.ptr[0]] = st.shift;
                            `GX_REG_DRV0, `GX_REG_DRV1,
                            `GX_REG_DRV2, `GX_REG_DRV3:
                                next_st.drv[st.ptr[1:0]] = st.shift;
                            `GX_REG_LAT0, `GX_REG_LAT1:
                                next_st.lat[st.ptr[0]] = st.shift;
                            `GX_REG_PEN0, `GX_REG_PEN1:
                                next_st.pen[st.ptr[0]] = st.shift;
                            `GX_REG_PSEL0, `GX_REG_PSEL1:
                                next_st.psel[st.ptr[0]] = st.shift;
                            `GX_REG_MASK0, `GX_REG_MASK1:
                                next_st.mask[st.ptr[0]] = st.shift;
                            `GX_REG_ODM:
                                next_st.odm = st.shift[1:0];
                            default: begin
                                // Input, status and unmapped writes drop.
                            end
                        endcase
                    end
                end
                gx_pkg::ST_RD: begin
                    if (st.bits == `GX_BYTE_BITS) begin
                        next_st.fsm = gx_pkg::ST_RACK;
                        next_st.sda_oe = 1'b0;
                        next_st.ptr = {st.ptr[7:1], ~st.ptr[0]};
                    end else begin
                        next_st.shift = {st.shift[6:0], 1'b0};
                        next_st.sda_oe = ~st.shift[6];
                    end
                end
                gx_pkg::ST_RACK: begin
                    next_st.fsm = gx_pkg::ST_RD;
                    next_st.bits = 4'h0;
                    next_st.shift = rd_data;
                    next_st.sda_oe = ~rd_data[7];
                    rd_in[st.ptr[0]] = (st.ptr[7:1] == 7'h00);
                end
                gx_pkg::ST_IDLE: begin
                end
            endcase
        end

        // The reference takes the value handed to software, so a change
        // that lands during the read raises the alert again next cycle.
        for (int p = 0; p < 2; p++) begin
            if (rd_in[p]) begin
                next_st.ref_val[p] = shown[p];
                next_st.flag[p] = 8'h00;
            end else begin
                next_st.flag[p] = (st.flag[p] | newly[p]) & st.lat[p];
                next_st.lval[p] = (newly[p] & in_val[p]) |
                                  (~newly[p] & st.lval[p]);
            end
        end

        next_st.alert_oe = |status;
        for (int i = 0; i < 16; i++) begin
            next_st.pins.oe[i] = ~st.cfg[i/8][i%8] &
                (~st.odm[i/8] | ~st.outp[i/8][i%8]);
        end
        next_st.pins.level = st.outp;
        next_st.pins.pull_en = st.pen;
        next_st.pins.pull_up = st.psel;
        next_st.pins.drive = st.drv;

        if (rst) begin
            next_st = '0;
            next_st.fsm = gx_pkg::ST_IDLE;
            next_st.outp = {2{`GX_OUT_RST}};
            next_st.pol = {2{`GX_POL_RST}};
            next_st.cfg = {2{`GX_CFG_RST}};
            next_st.drv = {4{`GX_DRV_RST}};
            next_st.lat = {2{`GX_LAT_RST}};
            next_st.pen = {2{`GX_PEN_RST}};
            next_st.psel = {2{`GX_PSEL_RST}};
            next_st.mask = {2{`GX_MASK_RST}};
            next_st.odm = `GX_ODM_RST;
            next_st.pins.level = {2{`GX_OUT_RST}};
            next_st.pins.pull_en = {2{`GX_PEN_RST}};
            next_st.pins.pull_up = {2{`GX_PSEL_RST}};
            next_st.pins.drive = {4{`GX_DRV_RST}};
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign pin_ctl = st.pins;
    assign sda_oe = st.sda_oe;
    assign sda_out = 1'b0;
    assign alert_n_oe = st.alert_oe;
    assign alert_n_out = 1'b0;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_MASK_RESET: assert property ($past(rst) |->
        st.mask == {2{`GX_MASK_RST}} && !st.alert_oe)
        else $error("mask not set after reset");
    AST_INPUT_RESET: assert property ($past(rst) |-> ##1
        pin_ctl.oe == 16'h0000)
        else $error("pin driven after reset");
    AST_PULL_RESET: assert property ($past(rst) |->
        pin_ctl.pull_en == 16'hFFFF && pin_ctl.pull_up == 16'hFFFF)
        else $error("pull-up not active after reset");
    AST_FSM_RESET: assert property ($past(rst) |->
        st.fsm == gx_pkg::ST_IDLE && !sda_oe)
        else $error("bus state not idle after reset");
    AST_ALERT: assert property (!$past(rst) |->
        alert_n_oe == |$past(status))
        else $error("alert does not follow status");
    AST_MASKED: assert property ((&st.mask) ##1 (&st.mask) |=>
        !alert_n_oe)
        else $error("masked pins raised the alert");
    AST_ADDR_MATCH: assert property (
        st.fsm == gx_pkg::ST_AACK |->
        st.shift[7:1] == {`GX_ADDR_PREFIX, pad.strap} && sda_oe)
        else $error("acknowledged a foreign address");
    AST_READ_DIR: assert property ((st.fsm == gx_pkg::ST_RD) |-> st.rnw)
        else $error("read phase entered for a write");
    AST_DIR_IN: assert property ((&st.cfg[0]) ##1 (&st.cfg[0]) |=>
        pin_ctl.oe[7:0] == 8'h00)
        else $error("input pin driven");
    AST_OPEN_DRAIN: assert property (
        (st.odm[1] && (&st.outp[1])) ##1 (st.odm[1] && (&st.outp[1])) |=>
        pin_ctl.oe[15:8] == 8'h00)
        else $error("open-drain bank drove a high level");
    AST_READ_CLEARS: assert property ($past(rd_in[0]) |->
        st.ref_val[0] == $past(shown[0]) && st.flag[0] == 8'h00)
        else $error("input read did not reset reference");

endmodule

// File: rtl/gx_pkg.sv
// Types shared by the expander core and its bench.
package gx_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_AACK,
        ST_CMD,
        ST_CACK,
        ST_WR,
        ST_WACK,
        ST_RD,
        ST_RACK
    } gx_fsm_type;

    // Bit 0 is bank0_pin0, bit 8 is bank1_pin0.
    typedef struct packed {
        logic [15:0] oe;
        logic [15:0] level;
        logic [15:0] pull_en;
        logic [15:0] pull_up;
        logic [31:0] drive;
    } gx_pin_ctl_type;

    typedef struct packed {
        logic scl;
        logic sda;
        logic [2:0] strap;
        logic [15:0] pin;
    } gx_pad_in_type;

    typedef struct packed {
        gx_fsm_type fsm;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic [3:0] bits;
        logic rnw;
        logic sda_oe;
        logic scl_d;
        logic sda_d;
        logic [1:0][7:0] outp;
        logic [1:0][7:0] pol;
        logic [1:0][7:0] cfg;
        logic [3:0][7:0] drv;
        logic [1:0][7:0] lat;
        logic [1:0][7:0] pen;
        logic [1:0][7:0] psel;
        logic [1:0][7:0] mask;
        logic [1:0][7:0] ref_val;
        logic [1:0][7:0] lval;
        logic [1:0][7:0] flag;
        logic [1:0] odm;
        logic alert_oe;
        gx_pin_ctl_type pins;
    } gx_core_state_type;

endpackage

// File: rtl/gx_sync.sv
// Two-flop synchroniser for signals arriving from outside the clock domain.
module gx_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gx_sync_state_type;

    gx_sync_state_type st;
    gx_sync_state_type next_st;

    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
        if (rst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign q = st.s2;

endmodule

// File: test/gx_bus_ctrl.sv
// Behavioural two-wire bus controller that drives the expander's serial bus.
module gx_bus_ctrl (
    output logic scl,
    output logic sda_pull,
    input wire logic sda_wire
);
    timeunit 1ns;
    timeprecision 100ps;
    // Half of the 125 ns bus clock; data moves 15 ns after each clock fall.
    localparam real HALF = 62.5;

    // The clock stands high between frames and the released data line
    // floats to its pull-up level.
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic start();
        // A 1 ns lead keeps the bus edges off the bench clock's edges.
        #1;
        if (!scl) begin
            #15 sda_pull = 1'b0;
            #(HALF - 15) scl = 1'b1;
        end
        #(HALF) sda_pull = 1'b1;
        #(HALF) scl = 1'b0;
    endtask

    task automatic stop();
        #15 sda_pull = 1'b1;
        #(HALF - 15) scl = 1'b1;
        #(HALF) sda_pull = 1'b0;
        #(HALF);
    endtask

    task automatic clock_bit(input logic b, output logic seen);
        #15 sda_pull = ~b;
        #(HALF - 15) scl = 1'b1;
        seen = sda_wire;
        #(HALF) scl = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            b[i] = s;
        end
        clock_bit(~ack, s);
    endtask
endmodule

// File: test/tb.sv
// Self-checking bench of the expander against a behavioural register model.
`include "gx_defs.svh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk;
    logic rst;
    logic scl;
    logic sda_pull;
    logic sda_out;
    logic sda_oe;
    logic alert_n_out;
    logic alert_n_oe;
    logic [2:0] strap;
    logic [15:0] pins;
    gx_pkg::gx_pin_ctl_type pin_ctl;
    logic [31:0] lfsr;
    logic [7:0] mreg [0:127];
    logic [7:0] mref [0:1];
    int n_fail;
    int samples_checked;
    int cycles;
    wire logic sda_wire;

    assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));

    gx_expander gx_expander_inst (
        .mclk(mclk),
        .rst(rst),
        .scl_in(scl),
        .sda_in(sda_wire),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .addr_strap_bit0(strap[0]),
        .addr_strap_bit1(strap[1]),
        .addr_strap_bit2(strap[2]),
        .pin_in(pins),
        .pin_ctl(pin_ctl),
        .alert_n_out(alert_n_out),
        .alert_n_oe(alert_n_oe)
    );

    gx_bus_ctrl gx_bus_ctrl_inst (
        .scl(scl),
        .sda_pull(sda_pull),
        .sda_wire(sda_wire)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // The tests take about 45000 cycles, so reaching this ceiling is a hang.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 90000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    function automatic logic [7:0] idx_of(input int k);
        return k < 8 ? 8'(k) : 8'(k + 'h38);
    endfunction

    function automatic bit writable(input logic [7:0] i);
        return (i >= 8'h02 && i < 8'h08) || (i >= 8'h40 && i < 8'h4C) ||
            i == 8'h4F;
    endfunction

    // Input and status views ignore latching; latch cases pass their own.
    function automatic logic [7:0] model_rd(input logic [7:0] i);
        logic [7:0] inp;
        inp = (i[0] ? pins[15:8] : pins[7:0]) ^ mreg[4 + i[0]];
        if (i < 2) return inp;
        if (i == 8'h4C || i == 8'h4D) begin
            return ~mreg[8'h4A + i[0]] & (inp ^ mref[i[0]]);
        end
        return writable(i) ? mreg[i] : 8'h00;
    endfunction

    task automatic reset_model();
        for (int i = 0; i < 128; i++) begin
            mreg[i] = (i >= 2 && i < 8 && i != 4 && i != 5) ? 8'hFF : 8'h00;
            if (i >= 8'h40 && i < 8'h4C && i != 8'h44 && i != 8'h45) begin
                mreg[i] = 8'hFF;
            end
        end
        mref[0] = 8'h00;
        mref[1] = 8'h00;
    endtask

    task automatic frame(input logic [7:0] idx);
        logic a;
        gx_bus_ctrl_inst.start();
        gx_bus_ctrl_inst.send_byte({`GX_ADDR_PREFIX, strap, 1'b0}, a);
        check("address ack", a, 1'b1);
        gx_bus_ctrl_inst.send_byte(idx, a);
        check("pointer ack", a, 1'b1);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic a;
        frame(idx);
        gx_bus_ctrl_inst.send_byte(d, a);
        gx_bus_ctrl_inst.stop();
        if (writable(idx)) begin
            mreg[idx] = idx == 8'h4F ? d & 8'h03 : d;
        end
        repeat (4) @(negedge mclk);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic a;
        logic [7:0] d;
        frame(idx);
        gx_bus_ctrl_inst.start();
        gx_bus_ctrl_inst.send_byte({`GX_ADDR_PREFIX, strap, 1'b1}, a);
        gx_bus_ctrl_inst.recv_byte(1'b0, d);
        gx_bus_ctrl_inst.stop();
        check($sformatf("register %h", idx), d, exp);
        if (idx < 2) begin
            mref[idx[0]] = exp;
        end
    endtask

    task automatic probe(input logic [6:0] addr, input logic exp);
        logic a;
        gx_bus_ctrl_inst.start();
        gx_bus_ctrl_inst.send_byte({addr, 1'b0}, a);
        gx_bus_ctrl_inst.stop();
        check("strap address ack", a, exp);
    endtask

    task automatic check_pins();
        logic [15:0] oe;
        for (int i = 0; i < 16; i++) begin
            oe[i] = ~mreg[6 + i / 8][i % 8] &
                (~mreg[8'h4F][i / 8] | ~mreg[2 + i / 8][i % 8]);
        end
        check("pin oe", pin_ctl.oe, oe);
        check("pin level", pin_ctl.level, {mreg[3], mreg[2]});
        check("pull_en", pin_ctl.pull_en, {mreg[8'h47], mreg[8'h46]});
        check("pull_up", pin_ctl.pull_up, {mreg[8'h49], mreg[8'h48]});
        check("drive", pin_ctl.drive, {mreg[8'h43], mreg[8'h42],
            mreg[8'h41], mreg[8'h40]});
        check("alert", {alert_n_oe, alert_n_out},
            {|(model_rd(8'h4C) | model_rd(8'h4D)), 1'b0});
    endtask

    initial begin
        logic [7:0] v;
        rst = 1'b1;
        strap = 3'h5;
        pins = 16'hA55A;
        lfsr = 32'h4F3BCA13;
        reset_model();
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        check_pins();
        for (int s = 0; s < 8; s++) begin
            @(negedge mclk) strap = 3'(s);
            repeat (5) @(negedge mclk);
            probe({`GX_ADDR_PREFIX, strap}, 1'b1);
            probe({`GX_ADDR_PREFIX, ~strap}, 1'b0);
            probe({`GX_ADDR_PREFIX ^ 4'h1, strap}, 1'b0);
        end
        for (int c = 0; c < 4; c++) begin
            wr(8'h40, {4{2'(c)}});
            check_pins();
        end
        @(negedge mclk) pins = 16'(rnd());
        // Latching stays off here so the plain input model holds.
        for (int k = 0; k < 24; k++) begin
            v = (k == 12 || k == 13) ? 8'h00 : 8'(rnd());
            wr(idx_of(k), v);
        end
        check_pins();
        for (int k = 0; k < 24; k++) begin
            rd_chk(idx_of(k), model_rd(idx_of(k)));
        end
        rd_chk(8'h10, 8'h00);
        wr(8'h06, 8'hFF);
        wr(8'h4A, 8'h00);
        wr(8'h4B, 8'hFF);
        rd_chk(8'h00, model_rd(8'h00));
        rd_chk(8'h01, model_rd(8'h01));
        @(negedge mclk) pins = pins ^ 16'h0101;
        repeat (8) @(negedge mclk);
        check("alert raised", alert_n_oe, 1'b1);
        rd_chk(8'h4C, 8'h01);
        rd_chk(8'h4D, 8'h00);
        rd_chk(8'h00, model_rd(8'h00));
        check("alert cleared", alert_n_oe, 1'b0);
        wr(8'h44, 8'h02);
        v = model_rd(8'h00);
        @(negedge mclk) pins = pins ^ 16'h0002;
        repeat (8) @(negedge mclk);
        pins = pins ^ 16'h0002;
        repeat (8) @(negedge mclk);
        check("alert held", alert_n_oe, 1'b1);
        rd_chk(8'h00, v ^ 8'h02);
        repeat (4) @(negedge mclk);
        rd_chk(8'h00, v);
        repeat (4) @(negedge mclk);
        check("alert after latch", alert_n_oe, 1'b0);
        wr(8'h03, 8'hFF);
        wr(8'h4F, 8'h02);
        check_pins();
        @(negedge mclk) rst = 1'b1;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        reset_model();
        repeat (4) @(negedge mclk);
        check_pins();
        for (int k = 0; k < 24; k++) begin
            rd_chk(idx_of(k), model_rd(idx_of(k)));
        end
        end_sim();
    end
endmodule
